/* File: hdl/pdm_microphone_capture.sv */
// Top of the PDM microphone capture block: clock, split, filter, DMA, APB registers
//
// Behaviour
// - Device drives microphone clock itself
// - Clock rate chosen by register field
// - Clock derived cleanly from source clock
// - Default: left falling, right rising edge
// - Swap field reverses the edges
// - Per-channel filter to 16-bit PCM
// - Output samples 16 bit, 16 kHz
// - Two microphones share one data line
// - DMA writes samples to RAM buffer
// - Stereo alternates L/R; mono left only
// - Start task begins, stop task ends
// - Stop finishes current frame first
// - Halt event after all writes done
// - Sample rate is mic clock / 64
// - Little-endian packing in 32-bit words
// - Pointer double-buffered after begun event
// - Full buffer: event, swap, begun
`timescale 1ns/1ps
module pdm_microphone_capture
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic micClockOut,
  input wire logic micDataIn,
  output logic [31:0] dmaAddr,
  output logic [31:0] dmaData,
  output logic dmaValid,
  input wire logic dmaReady
);

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,   // Clock low, nothing moves
    ST_RUN = 3'b010,    // Acquiring
    ST_DRAIN = 3'b100   // Stop asked, finishing frame
  } run_state_t;

  // ****************************************************************
  // Registers
  // ****************************************************************
  run_state_t stateReg, stateNext;                  // Acquisition state
  logic [7:0] rateReg, rateNext;                    // Clock rate select, half period
  logic [1:0] modeReg, modeNext;                    // Mono and swap bits
  logic [31:0] ptrReg, ptrNext;                     // Pointer loaded by software
  logic [31:0] curPtrReg, curPtrNext;               // Pointer in use
  logic [14:0] maxReg, maxNext;                     // Buffer size in samples
  logic [14:0] fillReg, fillNext;                   // Samples written so far
  logic evBegunReg, evBegunNext;                    // Buffer begun event
  logic evHaltReg, evHaltNext;                      // Halt done event
  logic evFullReg, evFullNext;                      // Buffer full event
  logic [7:0] divReg, divNext;                      // Clock divider count
  logic mclkReg, mclkNext;                          // Microphone clock level
  logic [31:0] wordReg, wordNext;                   // Word being assembled
  logic halfReg, halfNext;                          // Low half of mono word held
  logic pendReg, pendNext;                          // DMA word waiting
  logic [31:0] dmaAddrReg, dmaAddrNext;             // DMA address
  logic [31:0] dmaDataReg, dmaDataNext;             // DMA data
  logic [31:0] prdataReg, prdataNext;               // APB read data
  logic preadyReg, preadyNext;                      // APB ready
  logic pslverrReg, pslverrNext;                    // APB error
  logic dinSync1Reg, dinSync2Reg;                   // Data input synchroniser
  logic filtClear;                                  // Reset filters at start
  logic riseBit, fallBit;                           // Capture strobes
  logic leftValid, rightValid;
  logic [15:0] leftPcm, rightPcm;
  logic startTask, stopTask;                        // Write strobes
  logic apbAccess, bufDone; // Taken word fills buffer

  // Byte offset decode, used for reads and writes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction : hit

  // ****************************************************************
  // Input synchroniser
  // ****************************************************************
  // Data pin is asynchronous to clk; two flops before use
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dinSync1Reg <= 1'b0;
      dinSync2Reg <= 1'b0;
    end
    else if (clkEn)
    begin
      dinSync1Reg <= micDataIn;
      dinSync2Reg <= dinSync1Reg;
    end
  end

  // ****************************************************************
  // Channel filters
  // ****************************************************************
  // Bits are sampled just before each mic clock edge is driven; the
  // synchroniser delay is covered only for a rate of at least three cycles; RATE_MIN allows two.
  // The swap bit picks which edge feeds which filter
  logic leftStrobe, rightStrobe;
  assign leftStrobe = modeReg[pdm_capture_pkg::MODE_SWAP_BIT] ? riseBit : fallBit;
  assign rightStrobe = modeReg[pdm_capture_pkg::MODE_SWAP_BIT] ? fallBit : riseBit;

  pdm_decimator leftFilter
  (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .clear(filtClear),
    .bitValid(leftStrobe),
    .bitIn(dinSync2Reg),
    .pcmValid(leftValid),
    .pcmData(leftPcm)
  );

  pdm_decimator rightFilter
  (
    .clk(clk),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .clear(filtClear),
    .bitValid(rightStrobe),
    .bitIn(dinSync2Reg),
    .pcmValid(rightValid),
    .pcmData(rightPcm)
  );

  // ****************************************************************
  // APB decode
  // ****************************************************************
  assign apbAccess = psel && penable && !preadyReg;
  assign startTask = apbAccess && pwrite && hit(paddr, pdm_capture_pkg::OFF_START) && pwdata[0];
  assign stopTask = apbAccess && pwrite && hit(paddr, pdm_capture_pkg::OFF_STOP) && pwdata[0];
  assign filtClear = (stateReg == ST_IDLE);
  assign bufDone = pendReg && dmaReady && (fillReg >= maxReg);

  // Next values of all control and datapath state
  always_comb
  begin
    stateNext = stateReg;
    rateNext = rateReg;
    modeNext = modeReg;
    ptrNext = ptrReg;
    curPtrNext = curPtrReg;
    maxNext = maxReg;
    fillNext = fillReg;
    evBegunNext = evBegunReg;
    evHaltNext = evHaltReg;
    evFullNext = evFullReg;
    divNext = divReg;
    mclkNext = mclkReg;
    wordNext = wordReg;
    halfNext = halfReg;
    pendNext = pendReg;
    dmaAddrNext = dmaAddrReg;
    dmaDataNext = dmaDataReg;
    prdataNext = 32'h00000000;
    preadyNext = 1'b0;
    pslverrNext = 1'b0;
    riseBit = 1'b0;
    fallBit = 1'b0;

    // Mic clock divider, toggles only while running
    if (stateReg == ST_IDLE)
    begin
      divNext = 8'h00;
      mclkNext = 1'b0;
    end
    else if (divReg + 8'h01 >= rateReg)
    begin
      // Clean divide of clk: every edge on a clk edge, no added jitter
      divNext = 8'h00;
      mclkNext = !mclkReg;
      riseBit = !mclkReg;
      fallBit = mclkReg;
    end
    else
    begin
      divNext = divReg + 8'h01;
    end

    // DMA handshake completes a pending word
    if (pendReg && dmaReady)
    begin
      pendNext = 1'b0;
      if (fillReg >= maxReg)
      begin
        // Buffer full: event, switch pointer, begun again
        evFullNext = 1'b1;
        evBegunNext = 1'b1;
        curPtrNext = ptrReg;
        dmaAddrNext = ptrReg;
        fillNext = 15'h0000;
        if (stateReg == ST_DRAIN)
        begin
          // Frame done and write landed: halt
          stateNext = ST_IDLE;
          evHaltNext = 1'b1;
        end
      end
      else
      begin
        dmaAddrNext = dmaAddrReg + 32'h00000004;
      end
    end

    // Pack samples into words, little endian
    if (stateReg != ST_IDLE && !pendReg)
    begin
      if (modeReg[pdm_capture_pkg::MODE_MONO_BIT] && leftValid)
      begin
        if (halfReg)
        begin
          dmaDataNext = {leftPcm, wordReg[15:0]};
          pendNext = 1'b1;
          fillNext = fillReg + 15'h0002;
          halfNext = 1'b0;
        end
        else
        begin
          wordNext = {16'h0000, leftPcm};
          halfNext = 1'b1;
        end
      end
      else if (!modeReg[pdm_capture_pkg::MODE_MONO_BIT] && rightValid)
      begin
        // Right closes the word, left held from its frame
        dmaDataNext = {rightPcm, wordReg[15:0]};
        pendNext = 1'b1;
        fillNext = fillReg + 15'h0002;
      end
      else if (!modeReg[pdm_capture_pkg::MODE_MONO_BIT] && leftValid)
      begin
        wordNext = {16'h0000, leftPcm};
      end
    end

    // Start task begins acquisition; a start before halt is
    // ignored outside ST_IDLE, software must wait for the halt event
    if (startTask && stateReg == ST_IDLE)
    begin
      stateNext = ST_RUN;
      curPtrNext = ptrReg;
      dmaAddrNext = ptrReg;
      fillNext = 15'h0000;
      halfNext = 1'b0;
      evBegunNext = 1'b1;
    end
    else if (stopTask && stateReg == ST_RUN)
    begin
      // Stop waits for the current buffer to complete
      stateNext = ST_DRAIN;
    end

    // APB register access, one wait state, then pready for one cycle
    if (apbAccess)
    begin
      preadyNext = 1'b1;
      if (pwrite)
      begin
        if (hit(paddr, pdm_capture_pkg::OFF_CLKCTRL))
        begin
          rateNext = (pwdata[7:0] < pdm_capture_pkg::RATE_MIN) ?
            pdm_capture_pkg::RATE_MIN : pwdata[7:0];
        end
        else if (hit(paddr, pdm_capture_pkg::OFF_MODE))
        begin
          modeNext = pwdata[1:0];
        end
        else if (hit(paddr, pdm_capture_pkg::OFF_PTR))
        begin
          ptrNext = pwdata; // Shadow only, live pointer untouched
        end
        else if (hit(paddr, pdm_capture_pkg::OFF_MAXCNT))
        begin
          maxNext = pwdata[14:0];
        end
        else if (hit(paddr, pdm_capture_pkg::OFF_EVT_BEGUN))
        begin
          evBegunNext = (evBegunReg & pwdata[0]) | bufDone; // Set beats clear
        end
        else if (hit(paddr, pdm_capture_pkg::OFF_EVT_HALTED))
        begin
          evHaltNext = (evHaltReg & pwdata[0]) | (bufDone && stateReg == ST_DRAIN);
        end
        else if (hit(paddr, pdm_capture_pkg::OFF_EVT_FULL))
        begin
          evFullNext = (evFullReg & pwdata[0]) | bufDone;
        end
        else if (!hit(paddr, pdm_capture_pkg::OFF_START) && !hit(paddr, pdm_capture_pkg::OFF_STOP))
        begin
          pslverrNext = 1'b1; // Unmapped
        end
      end
      else
      begin
        if (hit(paddr, pdm_capture_pkg::OFF_CLKCTRL))
          prdataNext = {24'h000000, rateReg};
        else if (hit(paddr, pdm_capture_pkg::OFF_MODE))
          prdataNext = {30'h00000000, modeReg};
        else if (hit(paddr, pdm_capture_pkg::OFF_PTR))
          prdataNext = ptrReg;
        else if (hit(paddr, pdm_capture_pkg::OFF_MAXCNT))
          prdataNext = {17'h00000, maxReg};
        else if (hit(paddr, pdm_capture_pkg::OFF_EVT_BEGUN))
          prdataNext = {31'h00000000, evBegunReg};
        else if (hit(paddr, pdm_capture_pkg::OFF_EVT_HALTED))
          prdataNext = {31'h00000000, evHaltReg};
        else if (hit(paddr, pdm_capture_pkg::OFF_EVT_FULL))
          prdataNext = {31'h00000000, evFullReg};
        else if (hit(paddr, pdm_capture_pkg::OFF_STATUS))
          prdataNext = {14'h0000, fillReg, stateReg};
        else if (!hit(paddr, pdm_capture_pkg::OFF_START) && !hit(paddr, pdm_capture_pkg::OFF_STOP))
          pslverrNext = 1'b1;
      end
    end
  end

  // ****************************************************************
  // State registers
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stateReg <= ST_IDLE;
      rateReg <= pdm_capture_pkg::RATE_RESET;
      modeReg <= pdm_capture_pkg::MODE_RESET;
      ptrReg <= pdm_capture_pkg::PTR_RESET;
      curPtrReg <= pdm_capture_pkg::PTR_RESET;
      maxReg <= pdm_capture_pkg::MAXCNT_RESET;
      fillReg <= 15'h0000;
      evBegunReg <= 1'b0;
      evHaltReg <= 1'b0;
      evFullReg <= 1'b0;
      divReg <= 8'h00;
      mclkReg <= 1'b0;
      wordReg <= 32'h00000000;
      halfReg <= 1'b0;
      pendReg <= 1'b0;
      dmaAddrReg <= 32'h00000000;
      dmaDataReg <= 32'h00000000;
      prdataReg <= 32'h00000000;
      preadyReg <= 1'b0;
      pslverrReg <= 1'b0;
    end
    else if (clkEn)
    begin
      stateReg <= stateNext;
      rateReg <= rateNext;
      modeReg <= modeNext;
      ptrReg <= ptrNext;
      curPtrReg <= curPtrNext;
      maxReg <= maxNext;
      fillReg <= fillNext;
      evBegunReg <= evBegunNext;
      evHaltReg <= evHaltNext;
      evFullReg <= evFullNext;
      divReg <= divNext;
      mclkReg <= mclkNext;
      wordReg <= wordNext;
      halfReg <= halfNext;
      pendReg <= pendNext;
      dmaAddrReg <= dmaAddrNext;
      dmaDataReg <= dmaDataNext;
      prdataReg <= prdataNext;
      preadyReg <= preadyNext;
      pslverrReg <= pslverrNext;
    end
  end

  // Outputs straight from flops
  assign micClockOut = mclkReg;
  assign dmaAddr = dmaAddrReg;
  assign dmaData = dmaDataReg;
  assign dmaValid = pendReg;
  assign prdata = prdataReg;
  assign pready = preadyReg;
  assign pslverr = pslverrReg;

endmodule : pdm_microphone_capture

/* File: hdl/pdm_capture_pkg.sv */
// Package with register map, field layout and timing constants of the PDM capture block
package pdm_capture_pkg;

  // ****************************************************************
  // Register offsets (byte addresses on APB)
  // ****************************************************************
  localparam logic [11:0] OFF_START = 12'h000;        // Start task, write 1
  localparam logic [11:0] OFF_STOP = 12'h004;         // Stop task, write 1
  localparam logic [11:0] OFF_EVT_BEGUN = 12'h100;    // Buffer begun event
  localparam logic [11:0] OFF_EVT_HALTED = 12'h104;   // Halt done event
  localparam logic [11:0] OFF_EVT_FULL = 12'h108;     // Buffer full event
  localparam logic [11:0] OFF_CLKCTRL = 12'h504;      // Mic clock control
  localparam logic [11:0] OFF_MODE = 12'h508;         // Mode register
  localparam logic [11:0] OFF_PTR = 12'h560;          // DMA destination pointer
  localparam logic [11:0] OFF_MAXCNT = 12'h564;       // Buffer size in 16-bit samples
  localparam logic [11:0] OFF_STATUS = 12'h568;       // Block state, read only

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int MODE_MONO_BIT = 0;                   // 1 = mono, 0 = stereo
  localparam int MODE_SWAP_BIT = 1;                   // 1 = left on rising edge
  localparam int RATE_W = 8;                          // Clock rate select width
  localparam logic [7:0] RATE_RESET = 8'h08;          // Half period in clk cycles
  localparam logic [7:0] RATE_MIN = 8'h02;            // Least legal half period
  localparam logic [1:0] MODE_RESET = 2'h0;           // Stereo, default edges
  localparam logic [14:0] MAXCNT_RESET = 15'h0000;    // Empty buffer
  localparam logic [31:0] PTR_RESET = 32'h00000000;   // Pointer reset

  // ****************************************************************
  // Filter constants
  // ****************************************************************
  localparam int DECIM = 64;                          // Mic clocks per PCM sample
  localparam int CNT_W = 6;                           // Decimation counter width
  localparam int ACC_W = 18;                          // CIC accumulator width

endpackage : pdm_capture_pkg

/* File: hdl/pdm_decimator.sv */
// One channel of PDM to 16-bit PCM decimation
`timescale 1ns/1ps
module pdm_decimator
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic clear,
  input wire logic bitValid,
  input wire logic bitIn,
  output logic pcmValid,
  output logic [15:0] pcmData
);

  // ****************************************************************
  // Second order integrate and dump, rate 64
  // ****************************************************************
  // Cascade of running sums; a cheap filter in place of a long FIR
  logic [pdm_capture_pkg::ACC_W-1:0] int1Reg, int1Next;
  logic [pdm_capture_pkg::ACC_W-1:0] int2Reg, int2Next;
  logic [pdm_capture_pkg::ACC_W-1:0] combReg, combNext, comb2Reg, comb2Next;
  logic [pdm_capture_pkg::CNT_W-1:0] cntReg, cntNext;
  logic validReg, validNext;
  logic [15:0] dataReg, dataNext;
  logic [pdm_capture_pkg::ACC_W-1:0] diff, diff2;

  // Next state of the filter
  always_comb
  begin
    int1Next = int1Reg;
    int2Next = int2Reg;
    combNext = combReg;
    cntNext = cntReg;
    validNext = 1'b0;
    dataNext = dataReg;
    diff = int2Reg - combReg;
    comb2Next = comb2Reg;
    diff2 = diff - comb2Reg;
    if (clear)
    begin
      int1Next = '0;
      int2Next = '0;
      combNext = '0;
      comb2Next = '0;
      cntNext = '0;
    end
    else if (bitValid)
    begin
      // Bipolar input: 1 adds, 0 subtracts
      int1Next = bitIn ? int1Reg + 18'h00001 : int1Reg - 18'h00001;
      int2Next = int2Reg + int1Reg;
      cntNext = cntReg + 6'h01;
      if (cntReg == 6'h3F)
      begin
        // Dump once every 64 input bits
        combNext = int2Reg;
        comb2Next = diff;
        validNext = 1'b1;
        dataNext = diff2[17:2]; // Scale to 16 bits
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int1Reg <= '0;
      int2Reg <= '0;
      combReg <= '0;
      comb2Reg <= '0;
      cntReg <= '0;
      validReg <= 1'b0;
      dataReg <= 16'h0000;
    end
    else if (clkEn)
    begin
      int1Reg <= int1Next;
      int2Reg <= int2Next;
      combReg <= combNext;
      comb2Reg <= comb2Next;
      cntReg <= cntNext;
      validReg <= validNext;
      dataReg <= dataNext;
    end
  end

  assign pcmValid = validReg;
  assign pcmData = dataReg;

endmodule : pdm_decimator

/* File: verification/pdm_capture_sva.sv */
// Port checker of the PDM capture block: APB, DMA and mic clock timing
`timescale 1ns/1ps
module pdm_capture_sva
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic micClockOut,
  input wire logic [31:0] dmaAddr,
  input wire logic [31:0] dmaData,
  input wire logic dmaValid,
  input wire logic dmaReady
);
  // ****************************************
  // Helper state and properties
  // ****************************************
  logic [7:0] rate_reg; // Half period last written over APB
  logic [7:0] rate_next;
  logic [8:0] run_reg; // Cycles the mic clock held its level, saturating
  logic [8:0] run_next;
  logic lastMic_reg; // Mic clock one cycle ago
  logic lastMic_next;
  // Follow rate writes; count level length
  always_comb
  begin
    rate_next = rate_reg;
    if (psel && penable && pready && pwrite && !pslverr &&
        paddr == pdm_capture_pkg::OFF_CLKCTRL)
      rate_next = pwdata[7:0];
    lastMic_next = micClockOut;
    run_next = (micClockOut != lastMic_reg) ? 9'h001 : run_reg + {8'h00, run_reg != 9'h1FF};
  end
  // Long idle level assumed at reset, so the first rise is never short
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rate_reg <= pdm_capture_pkg::RATE_RESET;
      run_reg <= 9'h1FF;
      lastMic_reg <= 1'b0;
    end
    else
    begin
      rate_reg <= rate_next;
      run_reg <= run_next;
      lastMic_reg <= lastMic_next;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence apbWait;
    psel && penable && !pready;
  endsequence
  sequence dmaStall;
    dmaValid && !dmaReady;
  endsequence
  sequence micEdge;
    micClockOut != lastMic_reg;
  endsequence
  AST_APB_WAIT: assert property (apbWait |=> pready)
    else $error("pready missing after wait state");
  AST_APB_PULSE: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  AST_APB_CAUSE: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready without access phase");
  AST_APB_ERR: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_DMA_HOLD: assert property (dmaStall |=> dmaValid && $stable(dmaAddr) && $stable(dmaData))
    else $error("dma word changed while stalled");
  AST_DMA_DROP: assert property (dmaValid && dmaReady |=> !dmaValid)
    else $error("dma valid stays after take");
  AST_DMA_ALIGN: assert property (dmaValid |-> dmaAddr[1:0] == 2'h0)
    else $error("dma address not word aligned");
  AST_CLK_HIGH: assert property (micEdge and !micClockOut |-> run_reg <= {1'b0, rate_reg})
    else $error("mic clock high too long");
  AST_CLK_LOW: assert property (micEdge and micClockOut |-> run_reg >= {1'b0, rate_reg})
    else $error("mic clock low too short");
  COV_STALL: cover property (dmaStall ##1 dmaValid && dmaReady);
endmodule : pdm_capture_sva

bind pdm_microphone_capture pdm_capture_sva chk (.clk(clk), .rst_n(rst_n), .paddr(paddr),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .micClockOut(micClockOut), .dmaAddr(dmaAddr), .dmaData(dmaData),
  .dmaValid(dmaValid), .dmaReady(dmaReady));

/* File: verification/pdm_mic_pair.sv */
// Model of a left and a right PDM microphone on one data line
`timescale 1ns/1ps
module pdm_mic_pair
(
  input wire logic clk,
  input wire logic micClock,
  output logic micData
);
  logic lastClk = 1'b0; // Clock seen one cycle ago
  int quiet = 100; // Cycles since the last clock edge
  initial micData = 1'b0;
  // Left answers ones in the high phase, right zeros in the low; data lags one cycle
  always @(posedge clk)
  begin
    quiet <= (micClock != lastClk) ? 0 : quiet + 1;
    lastClk <= micClock;
    // Stopped clock: mics asleep, floating line shown as a toggling pattern
    if (quiet > 64)
      micData <= ~micData;
    else
      micData <= micClock;
  end
endmodule : pdm_mic_pair

/* File: verification/pdm_microphone_capture_tb.sv */
// Self-checking bench of the PDM capture block with a microphone pair
`timescale 1ns/1ps
module pdm_microphone_capture_tb;
  // ****************************************
  // Signals, design and partner
  // ****************************************
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic clkEn = 1'b1; // Held high: the freeze path is not exercised
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic micClockOut;
  logic micDataIn;
  logic [31:0] dmaAddr;
  logic [31:0] dmaData;
  logic dmaValid;
  logic dmaReady = 1'b1;
  logic stall = 1'b0; // Random RAM back-pressure when set
  logic [31:0] expAddr[$]; // Word addresses the DMA still owes
  logic [31:0] words[$]; // Words taken, oldest first
  realtime takeAt[$]; // Time of each take
  logic [31:0] rd;
  logic [31:0] wA; // Steady stereo word of the first run
  logic er;
  int err_total = 0;
  int n_compared = 0;
  initial forever #4 clk = ~clk;
  pdm_microphone_capture dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .micClockOut(micClockOut), .micDataIn(micDataIn),
    .dmaAddr(dmaAddr), .dmaData(dmaData), .dmaValid(dmaValid), .dmaReady(dmaReady));
  pdm_mic_pair mics (.clk(clk), .micClock(micClockOut), .micData(micDataIn));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // One APB transfer; waits up to 20 extra cycles for pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, pready}, 32'h1, "pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [11:0] a, input logic [31:0] e, input string what);
    apb(a, 1'b0, 32'h0);
    chk(rd, e, what);
  endtask : rchk
  // Poll an event until set, then clear it
  task automatic wait_evt(input logic [11:0] a);
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 5000)
    begin
      apb(a, 1'b0, 32'h0);
      n++;
    end
    chk(rd & 32'h1, 32'h1, "event");
    apb(a, 1'b1, 32'h0);
  endtask : wait_evt
  // Run bufs buffers of 8 samples; each buffer holds 4 words
  task automatic capture(input logic [1:0] mode, input logic [7:0] rate, input int bufs);
    logic [31:0] p;
    int n;
    words.delete();
    takeAt.delete();
    apb(pdm_capture_pkg::OFF_EVT_FULL, 1'b1, 32'h0);
    apb(pdm_capture_pkg::OFF_EVT_BEGUN, 1'b1, 32'h0);
    apb(pdm_capture_pkg::OFF_CLKCTRL, 1'b1, {24'h000000, rate});
    apb(pdm_capture_pkg::OFF_MODE, 1'b1, {30'h0, mode});
    apb(pdm_capture_pkg::OFF_MAXCNT, 1'b1, 32'h00000008);
    p = ($urandom & 32'h0000FFF0) | 32'h20000000;
    apb(pdm_capture_pkg::OFF_PTR, 1'b1, p);
    apb(pdm_capture_pkg::OFF_START, 1'b1, 32'h00000001);
    for (int b = 0; b < bufs; b++)
    begin
      wait_evt(pdm_capture_pkg::OFF_EVT_BEGUN);
      for (int i = 0; i < 4; i++)
        expAddr.push_back(p + 32'(4 * i));
      rchk(pdm_capture_pkg::OFF_EVT_FULL, {31'h0, b > 0}, "full event");
      apb(pdm_capture_pkg::OFF_EVT_FULL, 1'b1, 32'h0);
      p = p + 32'h00000100;
      if (b < bufs - 1)
        apb(pdm_capture_pkg::OFF_PTR, 1'b1, p);
      else
        apb(pdm_capture_pkg::OFF_STOP, 1'b1, 32'h00000001);
    end
    wait_evt(pdm_capture_pkg::OFF_EVT_HALTED);
    chk(32'(expAddr.size()), 32'h0, "words owed at halt");
    apb(pdm_capture_pkg::OFF_STATUS, 1'b0, 32'h0);
    chk({29'h0, rd[2:0]}, 32'h1, "idle state");
    n = 0;
    repeat (64) @(negedge clk) n += int'(micClockOut);
    chk(32'(n), 32'h0, "clock idle");
  endtask : capture
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // ****************************************
  // RAM side, monitor, watchdog, sequence
  // ****************************************
  always @(posedge clk) dmaReady <= !stall || ($urandom_range(2) != 0);
  // Every take is matched against the oldest owed address
  always @(negedge clk)
    if (dmaValid === 1'b1 && dmaReady === 1'b1)
    begin
      if (expAddr.size() == 0)
        chk(dmaAddr, 32'hFFFFFFFF, "extra word");
      else
        chk(dmaAddr, expAddr.pop_front(), "word address");
      words.push_back(dmaData);
      takeAt.push_back($realtime);
    end
  initial
  begin
    #600000;
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    tally_and_finish();
  end
  initial
  begin
    rd = $urandom(32'h03EC6336);
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rchk(pdm_capture_pkg::OFF_CLKCTRL, {24'h0, pdm_capture_pkg::RATE_RESET}, "rate");
    rchk(pdm_capture_pkg::OFF_MODE, {30'h0, pdm_capture_pkg::MODE_RESET}, "mode");
    rchk(pdm_capture_pkg::OFF_MAXCNT, {17'h0, pdm_capture_pkg::MAXCNT_RESET}, "size");
    rchk(pdm_capture_pkg::OFF_PTR, pdm_capture_pkg::PTR_RESET, "pointer");
    apb(pdm_capture_pkg::OFF_STATUS, 1'b1, 32'hFFFFFFFF);
    rchk(pdm_capture_pkg::OFF_STATUS, 32'h00000001, "status");
    apb(12'hFFC, 1'b0, 32'h0);
    chk({31'h0, er}, 32'h1, "unmapped");
    capture(2'h0, 8'h08, 2);
    chk(32'(int'(takeAt[3] - takeAt[2])), 32'h00002000, "stereo spacing");
    wA = words[7];
    chk({31'h0, $signed(wA[15:0]) > $signed(wA[31:16])}, 32'h1, "left low");
    stall = 1'b1;
    capture(2'h2, 8'h0A, 1);
    chk(words[3], {wA[15:0], wA[31:16]}, "swapped word");
    stall = 1'b0;
    capture(2'h1, 8'h08, 1);
    chk(32'(int'(takeAt[3] - takeAt[2])), 32'h00004000, "mono spacing");
    chk(words[3], {wA[15:0], wA[15:0]}, "mono word");
    tally_and_finish();
  end
endmodule : pdm_microphone_capture_tb
